// ==== hw/awf_defines.svh ====
// constants for the write address channel buffer
//
// Overview of operation
// [R1] every upstream address field is packed into the stored word
// [R2] every downstream address field is taken unchanged from the stored word
// [R3] upstream valid/ready handshake writes exactly one entry
// [R4] upstream ready is high when an entry can be accepted, low otherwise
// [R5] upstream master holds valid and fields stable until ready is seen
// [R6] downstream valid/ready handshake removes exactly one entry
// [R7] downstream valid high only with valid fields, held stable until ready
// [R8] burst length travels as an 8-bit field on both sides
// [R9] size, burst, lock, cache, prot, qos, region pass at full width
// [R10] AXI3 uses 4-bit length, 2-bit lock, no region; AXI4 8-bit length, 1-bit lock
// [R11] almost-full threshold input is sampled while reset is active; the code samples it on the first clock edge after reset release
// [R12] almost-full is high while occupancy is at or above the threshold
// [R13] ready low when full, valid low when empty, no overwrite or double read
`ifndef AWF_DEFINES_SVH
`define AWF_DEFINES_SVH

// default geometry
`define AWF_DEPTH 16
`define AWF_ID_W 4
`define AWF_ADDR_W 32
`define AWF_USER_W 1
`define AWF_AXI4 1

// control field widths
`define AWF_LEN_W 8
`define AWF_LEN3_W 4
`define AWF_SIZE_W 3
`define AWF_BURST_W 2
`define AWF_LOCK_W 2
`define AWF_LOCK4_W 1
`define AWF_CACHE_W 4
`define AWF_PROT_W 3
`define AWF_QOS_W 4
`define AWF_REGION_W 4

// reset values
`define AWF_THR_RST 12
`define AWF_CNT_RST 0

`endif

// ==== hw/awf_pkg.sv ====
// types of the write address channel buffer
`include "awf_defines.svh"

package awf_pkg;

    // fixed-width control fields of one address beat
    typedef struct packed {
        logic [`AWF_LEN_W-1:0] len;
        logic [`AWF_SIZE_W-1:0] size;
        logic [`AWF_BURST_W-1:0] burst;
        logic [`AWF_LOCK_W-1:0] lock;
        logic [`AWF_CACHE_W-1:0] cache;
        logic [`AWF_PROT_W-1:0] prot;
        logic [`AWF_QOS_W-1:0] qos;
        logic [`AWF_REGION_W-1:0] region;
    } awf_ctrl_t;

    // occupancy of the two-entry output buffer
    typedef enum logic [2:0] {
        AWF_BUF_EMPTY = 3'b001,
        AWF_BUF_ONE = 3'b010,
        AWF_BUF_TWO = 3'b100
    } awf_buf_state_t;

endpackage

// ==== hw/awf_aw_fifo.sv ====
// write address channel fifo with a two-entry output buffer
`timescale 1ns/10ps
`include "awf_defines.svh"

module awf_aw_fifo #(
    parameter int DEPTH = `AWF_DEPTH,
    parameter int ID_W = `AWF_ID_W,
    parameter int ADDR_W = `AWF_ADDR_W,
    parameter int USER_W = `AWF_USER_W,
    parameter int AXI4 = `AWF_AXI4
) (
    input wire logic CLK,
    input wire logic RSTN,
    // upstream slave side
    input wire logic [ID_W-1:0] S_AXI_AWID,
    input wire logic [ADDR_W-1:0] S_AXI_AWADDR,
    input wire logic [`AWF_LEN_W-1:0] S_AXI_AWLEN,
    input wire logic [`AWF_SIZE_W-1:0] S_AXI_AWSIZE,
    input wire logic [`AWF_BURST_W-1:0] S_AXI_AWBURST,
    input wire logic [`AWF_LOCK_W-1:0] S_AXI_AWLOCK,
    input wire logic [`AWF_CACHE_W-1:0] S_AXI_AWCACHE,
    input wire logic [`AWF_PROT_W-1:0] S_AXI_AWPROT,
    input wire logic [`AWF_QOS_W-1:0] S_AXI_AWQOS,
    input wire logic [`AWF_REGION_W-1:0] S_AXI_AWREGION,
    input wire logic [USER_W-1:0] S_AXI_AWUSER,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    // downstream master side
    output logic [ID_W-1:0] M_AXI_AWID,
    output logic [ADDR_W-1:0] M_AXI_AWADDR,
    output logic [`AWF_LEN_W-1:0] M_AXI_AWLEN,
    output logic [`AWF_SIZE_W-1:0] M_AXI_AWSIZE,
    output logic [`AWF_BURST_W-1:0] M_AXI_AWBURST,
    output logic [`AWF_LOCK_W-1:0] M_AXI_AWLOCK,
    output logic [`AWF_CACHE_W-1:0] M_AXI_AWCACHE,
    output logic [`AWF_PROT_W-1:0] M_AXI_AWPROT,
    output logic [`AWF_QOS_W-1:0] M_AXI_AWQOS,
    output logic [`AWF_REGION_W-1:0] M_AXI_AWREGION,
    output logic [USER_W-1:0] M_AXI_AWUSER,
    output logic M_AXI_AWVALID,
    input wire logic M_AXI_AWREADY,
    // sideband
    input wire logic [$clog2(DEPTH)-1:0] AW_ALMOST_FULL_THRESHOLD,
    output logic AW_ALMOST_FULL
);

    localparam int AW = $clog2(DEPTH);
    localparam int CW = $bits(awf_pkg::awf_ctrl_t);
    localparam int WW = ID_W + ADDR_W + CW + USER_W;
    localparam int OW = AW + 2;

    ////////////////////////////////////////////////////////////////////////////
    // elaboration checks

    // pointer wrap relies on a power-of-two depth
    if (DEPTH < 4 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
        $error("DEPTH must be a power of two and at least 4");
    end
    if (AXI4 != 0 && AXI4 != 1) begin : g_bad_axi4
        $error("AXI4 must be 0 or 1");
    end
    if (ID_W < 1 || ADDR_W < 1 || USER_W < 1) begin : g_bad_width
        $error("ID_W, ADDR_W and USER_W must be at least 1");
    end

    ////////////////////////////////////////////////////////////////////////////
    // field packing

    awf_pkg::awf_ctrl_t s_ctrl;
    awf_pkg::awf_ctrl_t m_ctrl;
    logic [WW-1:0] s_word;
    logic [WW-1:0] head_word;

    // variant masking: unused upper bits are stored as zero
    always_comb begin
        s_ctrl = '0;
        s_ctrl.size = S_AXI_AWSIZE; // [R9]
        s_ctrl.burst = S_AXI_AWBURST; // [R9]
        s_ctrl.cache = S_AXI_AWCACHE; // [R9]
        s_ctrl.prot = S_AXI_AWPROT; // [R9]
        s_ctrl.qos = S_AXI_AWQOS; // [R9]
        if (AXI4 == 1) begin
            s_ctrl.len = S_AXI_AWLEN; // [R8] [R10]
            s_ctrl.lock[`AWF_LOCK4_W-1:0] = S_AXI_AWLOCK[`AWF_LOCK4_W-1:0]; // [R10]
            s_ctrl.region = S_AXI_AWREGION; // [R9] [R10]
        end else begin
            s_ctrl.len[`AWF_LEN3_W-1:0] = S_AXI_AWLEN[`AWF_LEN3_W-1:0]; // [R10]
            s_ctrl.lock = S_AXI_AWLOCK; // [R10]
        end
    end

    // one stored word per address beat
    assign s_word = {S_AXI_AWID, S_AXI_AWADDR, s_ctrl, S_AXI_AWUSER}; // [R1]

    ////////////////////////////////////////////////////////////////////////////
    // storage fifo

    logic [WW-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr_reg;
    logic [AW-1:0] rd_ptr_reg;
    logic [AW:0] fifo_cnt_reg;
    logic [AW:0] fifo_cnt_next;
    logic fifo_full;
    logic fifo_empty;
    logic push;
    logic take;
    logic pop;
    logic buf_room;

    assign fifo_full = (fifo_cnt_reg == (AW + 1)'(DEPTH));
    assign fifo_empty = (fifo_cnt_reg == '0);

    // ready depends only on state, never on valid, so no loop upstream
    assign S_AXI_AWREADY = !fifo_full; // [R4] [R13]
    assign push = S_AXI_AWVALID && !fifo_full; // [R3]

    // head moves into the output buffer whenever it has room
    assign take = !fifo_empty && buf_room; // [R13]
    assign head_word = mem[rd_ptr_reg];

    // memory array, no reset needed on data
    always_ff @(posedge CLK) begin
        if (push) begin
            mem[wr_ptr_reg] <= s_word; // [R3]
        end
    end

    // write pointer
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            wr_ptr_reg <= '0;
        end else if (push) begin
            wr_ptr_reg <= wr_ptr_reg + 1'b1; // [R3]
        end
    end

    // read pointer
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            rd_ptr_reg <= '0;
        end else if (take) begin
            rd_ptr_reg <= rd_ptr_reg + 1'b1;
        end
    end

    // fill count
    always_comb begin
        fifo_cnt_next = fifo_cnt_reg;
        if (push && !take) begin
            fifo_cnt_next = fifo_cnt_reg + 1'b1;
        end else if (take && !push) begin
            fifo_cnt_next = fifo_cnt_reg - 1'b1;
        end
    end

    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            fifo_cnt_reg <= (AW + 1)'(`AWF_CNT_RST);
        end else begin
            fifo_cnt_reg <= fifo_cnt_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // two-entry output buffer

    awf_pkg::awf_buf_state_t buf_state_reg;
    awf_pkg::awf_buf_state_t buf_state_next;
    logic [WW-1:0] buf0_reg;
    logic [WW-1:0] buf1_reg;
    logic [1:0] buf_cnt;
    logic [1:0] buf_cnt_next;

    // a stall downstream fills this buffer, then the fifo, then upstream
    assign buf_room = (buf_state_reg != awf_pkg::AWF_BUF_TWO);
    assign M_AXI_AWVALID = (buf_state_reg != awf_pkg::AWF_BUF_EMPTY); // [R7] [R13]
    assign pop = M_AXI_AWVALID && M_AXI_AWREADY; // [R6]

    // occupancy state
    always_comb begin
        buf_state_next = buf_state_reg;
        unique case (buf_state_reg)
            awf_pkg::AWF_BUF_EMPTY: begin
                if (take) begin
                    buf_state_next = awf_pkg::AWF_BUF_ONE;
                end
            end
            awf_pkg::AWF_BUF_ONE: begin
                if (take && !pop) begin
                    buf_state_next = awf_pkg::AWF_BUF_TWO;
                end else if (pop && !take) begin
                    buf_state_next = awf_pkg::AWF_BUF_EMPTY;
                end
            end
            awf_pkg::AWF_BUF_TWO: begin
                if (pop) begin
                    buf_state_next = awf_pkg::AWF_BUF_ONE; // [R6]
                end
            end
            default: begin
                buf_state_next = awf_pkg::AWF_BUF_EMPTY;
            end
        endcase
    end

    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            buf_state_reg <= awf_pkg::AWF_BUF_EMPTY;
        end else begin
            buf_state_reg <= buf_state_next;
        end
    end

    // head entry: changes only on a handshake or when loading while empty
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            buf0_reg <= '0;
        end else begin
            unique case (buf_state_reg)
                awf_pkg::AWF_BUF_EMPTY: begin
                    if (take) begin
                        buf0_reg <= head_word;
                    end
                end
                awf_pkg::AWF_BUF_ONE: begin
                    if (pop && take) begin
                        buf0_reg <= head_word; // [R7]
                    end
                end
                awf_pkg::AWF_BUF_TWO: begin
                    if (pop) begin
                        buf0_reg <= buf1_reg; // [R7]
                    end
                end
                default: begin
                    buf0_reg <= buf0_reg;
                end
            endcase
        end
    end

    // second entry: catches the word that arrives while the head stalls
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            buf1_reg <= '0;
        end else if (buf_state_reg == awf_pkg::AWF_BUF_ONE && take && !pop) begin
            buf1_reg <= head_word;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // field unpacking

    assign m_ctrl = buf0_reg[USER_W +: CW];
    assign M_AXI_AWUSER = buf0_reg[USER_W-1:0]; // [R2]
    assign M_AXI_AWADDR = buf0_reg[USER_W + CW +: ADDR_W]; // [R2]
    assign M_AXI_AWID = buf0_reg[USER_W + CW + ADDR_W +: ID_W]; // [R2]
    assign M_AXI_AWLEN = m_ctrl.len; // [R2] [R8]
    assign M_AXI_AWSIZE = m_ctrl.size; // [R9]
    assign M_AXI_AWBURST = m_ctrl.burst; // [R9]
    assign M_AXI_AWLOCK = m_ctrl.lock; // [R9]
    assign M_AXI_AWCACHE = m_ctrl.cache; // [R9]
    assign M_AXI_AWPROT = m_ctrl.prot; // [R9]
    assign M_AXI_AWQOS = m_ctrl.qos; // [R9]
    assign M_AXI_AWREGION = m_ctrl.region; // [R9] [R10]

    ////////////////////////////////////////////////////////////////////////////
    // almost-full threshold and flag

    logic [AW-1:0] thr_reg;
    logic thr_loaded_reg;
    logic [OW-1:0] occ_next;

    // threshold latched on the first edge after release; async reset
    // cannot load a port value, so the flag arms a clocked capture
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            thr_loaded_reg <= 1'b0;
        end else begin
            thr_loaded_reg <= 1'b1;
        end
    end

    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            thr_reg <= AW'(`AWF_THR_RST);
        end else if (!thr_loaded_reg) begin
            thr_reg <= AW_ALMOST_FULL_THRESHOLD; // [R11]
        end
    end

    // occupancy counts both the fifo and the output buffer
    always_comb begin
        unique case (buf_state_next)
            awf_pkg::AWF_BUF_EMPTY: buf_cnt_next = 2'h0;
            awf_pkg::AWF_BUF_ONE: buf_cnt_next = 2'h1;
            awf_pkg::AWF_BUF_TWO: buf_cnt_next = 2'h2;
            default: buf_cnt_next = 2'h0;
        endcase
        buf_cnt = buf_cnt_next;
        occ_next = OW'(fifo_cnt_next) + OW'(buf_cnt);
    end

    // flag is registered from next occupancy so it tracks the same edge;
    // on the capture edge the flag compares against the port value being latched, not the old thr_reg
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            AW_ALMOST_FULL <= 1'b0;
        end else if (!thr_loaded_reg) begin
            AW_ALMOST_FULL <= (occ_next >= OW'(AW_ALMOST_FULL_THRESHOLD)); // [R12]
        end else begin
            AW_ALMOST_FULL <= (occ_next >= OW'(thr_reg)); // [R12]
        end
    end

endmodule

// ==== test/awf_aw_fifo_props.sv ====
// checker for the write address channel buffer
`timescale 1ns/10ps
`include "awf_defines.svh"

module awf_aw_fifo_props #(
    parameter int DEPTH = 16,
    parameter int ID_W = 4,
    parameter int ADDR_W = 32,
    parameter int AXI4 = 1
) (
    input wire logic CLK,
    input wire logic RSTN,
    input wire logic S_AXI_AWVALID,
    input wire logic S_AXI_AWREADY,
    input wire logic [ID_W-1:0] M_AXI_AWID,
    input wire logic [ADDR_W-1:0] M_AXI_AWADDR,
    input wire logic [`AWF_LEN_W-1:0] M_AXI_AWLEN,
    input wire logic [`AWF_LOCK_W-1:0] M_AXI_AWLOCK,
    input wire logic M_AXI_AWVALID,
    input wire logic M_AXI_AWREADY,
    input wire logic [$clog2(DEPTH)-1:0] AW_ALMOST_FULL_THRESHOLD,
    input wire logic AW_ALMOST_FULL
);
    default clocking @(posedge CLK); endclocking
    default disable iff (!RSTN);
    logic [7:0] occ_reg;
    logic [7:0] thr_reg;
    logic started_reg;
    wire logic s_hs = S_AXI_AWVALID && S_AXI_AWREADY;
    wire logic m_hs = M_AXI_AWVALID && M_AXI_AWREADY;
    ////////////////////////////////////////
    // occupancy seen from both handshakes, buffer included
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            occ_reg <= 8'h00;
        end else begin
            occ_reg <= occ_reg + 8'(s_hs) - 8'(m_hs);
        end
    end
    // threshold is only taken on the first edge after release
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            started_reg <= 1'h0;
            thr_reg <= 8'h00;
        end else begin
            started_reg <= 1'h1;
            if (!started_reg) begin
                thr_reg <= 8'(AW_ALMOST_FULL_THRESHOLD);
            end
        end
    end
    ////////////////////////////////////////
    property p_ready_free;
        occ_reg < DEPTH |-> S_AXI_AWREADY;
    endproperty
    a_ready_free: assert property (p_ready_free) else $error("ready low with room");
    property p_ready_full;
        occ_reg == DEPTH + 2 |-> !S_AXI_AWREADY;
    endproperty
    a_ready_full: assert property (p_ready_full) else $error("ready high when full");
    property p_valid_empty;
        occ_reg == 0 |-> !M_AXI_AWVALID;
    endproperty
    a_valid_empty: assert property (p_valid_empty) else $error("valid when empty");
    property p_valid_soon;
        occ_reg != 0 |-> ##[0:2] M_AXI_AWVALID;
    endproperty
    a_valid_soon: assert property (p_valid_soon) else $error("stored entry not offered");
    property p_hold;
        M_AXI_AWVALID && !M_AXI_AWREADY |=> M_AXI_AWVALID
            && $stable({M_AXI_AWID, M_AXI_AWADDR, M_AXI_AWLEN, M_AXI_AWLOCK});
    endproperty
    a_hold: assert property (p_hold) else $error("offer changed before ready");
    property p_latency;
        s_hs && occ_reg == 0 |=> !M_AXI_AWVALID ##1 M_AXI_AWVALID;
    endproperty
    a_latency: assert property (p_latency) else $error("write not offered after two edges");
    property p_drop;
        m_hs && occ_reg == 1 |=> !M_AXI_AWVALID;
    endproperty
    a_drop: assert property (p_drop) else $error("last entry offered twice");
    property p_afull;
        started_reg |-> AW_ALMOST_FULL == (occ_reg >= thr_reg);
    endproperty
    a_afull: assert property (p_afull) else $error("almost full flag wrong");
    property p_lock;
        M_AXI_AWVALID |-> ((AXI4 == 1) ? !M_AXI_AWLOCK[1] : (M_AXI_AWLEN[7:4] == 4'h0));
    endproperty
    a_lock: assert property (p_lock) else $error("masked variant bits driven");
    c_full: cover property (occ_reg == DEPTH + 2);
    c_stall: cover property (M_AXI_AWVALID && !M_AXI_AWREADY ##1 m_hs);
    c_both: cover property (s_hs && m_hs);
endmodule

bind awf_aw_fifo awf_aw_fifo_props #(
    .DEPTH(DEPTH), .ID_W(ID_W), .ADDR_W(ADDR_W), .AXI4(AXI4)) i_props (
    .CLK(CLK), .RSTN(RSTN), .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY),
    .M_AXI_AWID(M_AXI_AWID), .M_AXI_AWADDR(M_AXI_AWADDR), .M_AXI_AWLEN(M_AXI_AWLEN),
    .M_AXI_AWLOCK(M_AXI_AWLOCK), .M_AXI_AWVALID(M_AXI_AWVALID), .M_AXI_AWREADY(M_AXI_AWREADY),
    .AW_ALMOST_FULL_THRESHOLD(AW_ALMOST_FULL_THRESHOLD), .AW_ALMOST_FULL(AW_ALMOST_FULL));

// ==== test/awf_sink_model.sv ====
// downstream address slave model with selectable stalling
`timescale 1ns/10ps

module awf_sink_model (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [1:0] mode,
    output logic ready
);
    // mode 0 always ready, 1 random stalls, 2 stalled for good
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ready <= 1'h0;
        end else begin
            ready <= (mode == 2'h0) || (mode == 2'h1 && $urandom_range(1) == 1);
        end
    end
endmodule

// ==== test/test_awf_aw_fifo.sv ====
// self-checking bench for the write address channel buffer
`timescale 1ns/10ps

module test_awf_aw_fifo;
    localparam int DEPTH = 4;
    logic CLK = 1'h0;
    logic RSTN = 1'h0;
    logic s_valid = 1'h0;
    logic [3:0] s_id = 4'h0;
    logic [31:0] s_addr = 32'h0;
    awf_pkg::awf_ctrl_t s_ctrl = '0;
    logic [0:0] s_user = 1'h0;
    logic [1:0] thr = 2'h3;
    logic [1:0] mode = 2'h0;
    wire logic s_ready, m_valid, m_ready, afull;
    wire logic [3:0] m_id;
    wire logic [31:0] m_addr;
    wire awf_pkg::awf_ctrl_t m_ctrl;
    wire logic [0:0] m_user;
    wire logic s3_ready, m3_valid;
    wire logic [3:0] m3_id;
    wire logic [31:0] m3_addr;
    wire awf_pkg::awf_ctrl_t m3_ctrl;
    wire logic [0:0] m3_user;
    logic [66:0] exp_q[$];
    logic [66:0] exp3_q[$];
    int n_fail = 0;
    int samples_checked = 0;
    int occ = 0;
    int thr_m = 0;
    bit started = 0;
    ////////////////////////////////////////
    awf_aw_fifo #(.DEPTH(DEPTH)) i_awf_aw_fifo (
        .CLK(CLK), .RSTN(RSTN), .S_AXI_AWID(s_id), .S_AXI_AWADDR(s_addr),
        .S_AXI_AWLEN(s_ctrl.len), .S_AXI_AWSIZE(s_ctrl.size), .S_AXI_AWBURST(s_ctrl.burst),
        .S_AXI_AWLOCK(s_ctrl.lock), .S_AXI_AWCACHE(s_ctrl.cache), .S_AXI_AWPROT(s_ctrl.prot),
        .S_AXI_AWQOS(s_ctrl.qos), .S_AXI_AWREGION(s_ctrl.region), .S_AXI_AWUSER(s_user),
        .S_AXI_AWVALID(s_valid), .S_AXI_AWREADY(s_ready), .M_AXI_AWID(m_id),
        .M_AXI_AWADDR(m_addr), .M_AXI_AWLEN(m_ctrl.len), .M_AXI_AWSIZE(m_ctrl.size),
        .M_AXI_AWBURST(m_ctrl.burst), .M_AXI_AWLOCK(m_ctrl.lock), .M_AXI_AWCACHE(m_ctrl.cache),
        .M_AXI_AWPROT(m_ctrl.prot), .M_AXI_AWQOS(m_ctrl.qos), .M_AXI_AWREGION(m_ctrl.region),
        .M_AXI_AWUSER(m_user), .M_AXI_AWVALID(m_valid), .M_AXI_AWREADY(m_ready),
        .AW_ALMOST_FULL_THRESHOLD(thr), .AW_ALMOST_FULL(afull));
    // narrow-length variant on the same stimulus and sink, so its masking is exercised
    awf_aw_fifo #(.DEPTH(DEPTH), .AXI4(0)) i_awf_aw_fifo_axi3 (
        .CLK(CLK), .RSTN(RSTN), .S_AXI_AWID(s_id), .S_AXI_AWADDR(s_addr),
        .S_AXI_AWLEN(s_ctrl.len), .S_AXI_AWSIZE(s_ctrl.size), .S_AXI_AWBURST(s_ctrl.burst),
        .S_AXI_AWLOCK(s_ctrl.lock), .S_AXI_AWCACHE(s_ctrl.cache), .S_AXI_AWPROT(s_ctrl.prot),
        .S_AXI_AWQOS(s_ctrl.qos), .S_AXI_AWREGION(s_ctrl.region), .S_AXI_AWUSER(s_user),
        .S_AXI_AWVALID(s_valid), .S_AXI_AWREADY(s3_ready), .M_AXI_AWID(m3_id),
        .M_AXI_AWADDR(m3_addr), .M_AXI_AWLEN(m3_ctrl.len), .M_AXI_AWSIZE(m3_ctrl.size),
        .M_AXI_AWBURST(m3_ctrl.burst), .M_AXI_AWLOCK(m3_ctrl.lock),
        .M_AXI_AWCACHE(m3_ctrl.cache), .M_AXI_AWPROT(m3_ctrl.prot),
        .M_AXI_AWQOS(m3_ctrl.qos), .M_AXI_AWREGION(m3_ctrl.region),
        .M_AXI_AWUSER(m3_user), .M_AXI_AWVALID(m3_valid), .M_AXI_AWREADY(m_ready),
        .AW_ALMOST_FULL_THRESHOLD(thr), .AW_ALMOST_FULL());
    awf_sink_model i_awf_sink_model (.clk(CLK), .rstn(RSTN), .mode(mode), .ready(m_ready));
    initial forever #2.5 CLK = ~CLK;
    ////////////////////////////////////////
    task automatic chk_word(input string what, input logic [66:0] e, input logic [66:0] g);
        samples_checked++;
        if (g !== e) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic chk_bit(input string what, input logic e, input logic g);
        samples_checked++;
        if (g !== e) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic print_verdict();
        $display("checked %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // threshold wanders while reset is held, final value must win
    task automatic do_reset(input logic [1:0] t);
        RSTN <= 1'h0;
        thr <= 2'($urandom);
        repeat (6) @(posedge CLK);
        thr <= t;
        repeat (6) @(posedge CLK);
        RSTN <= 1'h1;
    endtask
    // upstream master: fields held with valid until ready is sampled
    task automatic push(input int n, input bit gaps);
        int k;
        repeat (n) begin
            s_id <= 4'($urandom);
            s_addr <= $urandom;
            s_ctrl <= 30'($urandom);
            s_user <= 1'($urandom);
            s_valid <= 1'h1;
            k = 0;
            do begin
                @(posedge CLK);
                k++;
            end while (s_ready !== 1'h1 && k < 200);
            if (k >= 200) n_fail++;
            if (gaps && $urandom_range(1) == 1) begin
                s_valid <= 1'h0;
                @(posedge CLK);
            end
        end
        s_valid <= 1'h0;
        @(posedge CLK);
    endtask
    task automatic drain();
        int k;
        k = 0;
        while ((exp_q.size() != 0 || m_valid !== 1'h0 || exp3_q.size() != 0
                || m3_valid !== 1'h0) && k < 300) begin
            @(posedge CLK);
            k++;
        end
        if (k >= 300) n_fail++;
        repeat (2) @(posedge CLK);
    endtask
    ////////////////////////////////////////
    // reference model: queue of words and occupancy count
    always @(posedge CLK) begin
        awf_pkg::awf_ctrl_t ec;
        if (!RSTN) begin
            exp_q.delete();
            exp3_q.delete();
            occ = 0;
            started = 0;
        end else begin
            if (started) chk_bit("almost_full", occ >= thr_m, afull);
            if (!started) thr_m = thr;
            started = 1;
            if (s_valid && s_ready) begin
                ec = s_ctrl;
                ec.lock[1] = 1'h0;
                exp_q.push_back({s_id, s_addr, ec, s_user});
                occ++;
            end
            // narrow variant keeps 4 length bits, both lock bits and no region
            if (s_valid && s3_ready) begin
                ec = s_ctrl;
                ec.len[7:4] = 4'h0;
                ec.region = 4'h0;
                exp3_q.push_back({s_id, s_addr, ec, s_user});
            end
            if (m_valid && m_ready) begin
                ec = m_ctrl;
                chk_word("aw_word", exp_q.size() ? exp_q.pop_front() : 'x,
                    {m_id, m_addr, ec, m_user});
                occ--;
            end
            if (m3_valid && m_ready) begin
                chk_word("aw3_word", exp3_q.size() ? exp3_q.pop_front() : 'x,
                    {m3_id, m3_addr, m3_ctrl, m3_user});
            end
        end
    end
    initial begin
        #(5 * 4000);
        n_fail++;
        print_verdict();
    end
    initial begin
        void'($urandom(69));
        do_reset(2'h3);
        mode <= 2'h1;
        push(24, 1);
        drain();
        $display("test stream done");
        mode <= 2'h2;
        thr <= 2'h1; // ignored after release
        push(DEPTH + 2, 0);
        repeat (3) @(posedge CLK);
        chk_bit("s_ready_full", 1'h0, s_ready);
        chk_bit("s3_ready_full", 1'h0, s3_ready);
        mode <= 2'h0;
        drain();
        chk_bit("m_valid_empty", 1'h0, m_valid);
        chk_bit("m3_valid_empty", 1'h0, m3_valid);
        $display("test fill done");
        mode <= 2'h2;
        push(3, 0);
        do_reset(2'h0);
        @(posedge CLK);
        chk_bit("m_valid_reset", 1'h0, m_valid);
        mode <= 2'h0;
        push(16, 0);
        drain();
        $display("test reset and burst done");
        print_verdict();
    end
endmodule
